// [rtl/peb_host.sv]
// Host controller driving the byte-wide paged memory through its pins.
//
// Contract
// - ID area: elevated address pin, top range
// - Six-byte erase code written as ordinary writes
// - Page lines constant through one load
// - Gate high while strobe and select low
`timescale 1ns/1ps
`default_nettype none
module peb_host #(
  parameter int unsigned WC_CYCLES = peb_pkg::CYC_WC_SLOW,
  parameter int unsigned BLC_CYCLES = peb_pkg::CYC_BLC,
  parameter int unsigned ERASE_CYCLES = peb_pkg::CYC_ERASE_PULSE,
  parameter int unsigned ERASE_SETUP_CYCLES = peb_pkg::CYC_ERASE_SETUP
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // User command port
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic cmd_id_area,
  input wire logic cmd_last,
  input wire logic [14:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic rsp_timeout,
  // Memory pins
  output logic [14:0] mem_addr,
  output logic mem_cs_n,
  output logic mem_oe_n,
  output logic mem_we_n,
  output logic mem_oe_elevated,
  output logic mem_id_elevated,
  input wire logic [7:0] mem_dq_in,
  output logic [7:0] mem_dq_out,
  output logic mem_dq_oe
);

  peb_pkg::peb_state_e state_q;
  logic [peb_pkg::CNT_W-1:0] tmr_count;
  logic tmr_load, tmr_done;
  logic [7:0] last_wdata_q;
  logic [14:0] last_addr_q;
  logic [8:0] page_q;
  logic [23:0] wc_q;
  logic prev_toggle_q;
  logic page_open_q;
  logic last_q;
  logic [7:0] we_low_q;

  peb_timer u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
  );

  // A new page byte continues the load only on the same page inside the window.
  logic same_page;
  assign same_page = page_open_q && (cmd_addr[14:6] == page_q)
    && (cmd_id_area == mem_id_elevated);

  always_comb begin
    tmr_load = 1'b0;
    tmr_count = '0;
    case (state_q)
      peb_pkg::PEB_ST_IDLE: begin
        if (cmd_valid && cmd_op == peb_pkg::PEB_CMD_ERASE) begin
          tmr_load = 1'b1;
          tmr_count = peb_pkg::CNT_W'(ERASE_SETUP_CYCLES);
        end else if (cmd_valid && cmd_op != peb_pkg::PEB_CMD_WRITE) begin
          tmr_load = 1'b1;
          tmr_count = peb_pkg::CNT_W'(peb_pkg::CYC_ACC);
        end else if (cmd_valid) begin
          tmr_load = 1'b1;
          tmr_count = peb_pkg::CNT_W'(peb_pkg::CYC_WPH);
        end
      end
      peb_pkg::PEB_ST_WR_SETUP: begin
        tmr_load = tmr_done;
        tmr_count = peb_pkg::CNT_W'(peb_pkg::CYC_WP);
      end
      peb_pkg::PEB_ST_WR_LOW: begin
        tmr_load = tmr_done;
        tmr_count = peb_pkg::CNT_W'(peb_pkg::CYC_WPH);
      end
      peb_pkg::PEB_ST_WR_HIGH: begin
        tmr_load = tmr_done;
        // Leave margin under the window so the next byte surely lands in time.
        tmr_count = peb_pkg::CNT_W'(BLC_CYCLES - peb_pkg::CYC_ACC);
      end
      peb_pkg::PEB_ST_PAGE_WAIT: begin
        tmr_load = !tmr_done && cmd_valid && cmd_op == peb_pkg::PEB_CMD_WRITE && same_page;
        tmr_count = peb_pkg::CNT_W'(peb_pkg::CYC_WPH);
      end
      peb_pkg::PEB_ST_POLL_RD: begin
        tmr_load = tmr_done;
        tmr_count = peb_pkg::CNT_W'(peb_pkg::CYC_OEHP);
      end
      peb_pkg::PEB_ST_POLL_GAP: begin
        tmr_load = tmr_done;
        tmr_count = peb_pkg::CNT_W'(peb_pkg::CYC_ACC);
      end
      peb_pkg::PEB_ST_ER_SETUP: begin
        tmr_load = tmr_done;
        tmr_count = peb_pkg::CNT_W'(ERASE_CYCLES);
      end
      peb_pkg::PEB_ST_ER_PULSE: begin
        tmr_load = tmr_done;
        tmr_count = peb_pkg::CNT_W'(ERASE_SETUP_CYCLES);
      end
      default: begin
        tmr_load = 1'b0;
        tmr_count = '0;
      end
    endcase
  end

  // Sequencer and pin drive.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= peb_pkg::PEB_ST_IDLE;
      mem_addr <= '0;
      mem_cs_n <= 1'b1;
      mem_oe_n <= 1'b1;
      mem_we_n <= 1'b1;
      mem_oe_elevated <= 1'b0;
      mem_id_elevated <= 1'b0;
      mem_dq_out <= '0;
      mem_dq_oe <= 1'b0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      rsp_timeout <= 1'b0;
      last_wdata_q <= '0;
      last_addr_q <= '0;
      page_q <= '0;
      prev_toggle_q <= 1'b0;
      page_open_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      cmd_ready <= 1'b0;
      case (state_q)
        peb_pkg::PEB_ST_IDLE: begin
          mem_cs_n <= 1'b1;
          mem_oe_n <= 1'b1;
          mem_we_n <= 1'b1;
          mem_dq_oe <= 1'b0;
          if (cmd_valid) begin
            cmd_ready <= 1'b1;
            mem_addr <= cmd_addr;
            mem_id_elevated <= cmd_id_area && (cmd_addr >= peb_pkg::ID_BASE);
            if (cmd_op == peb_pkg::PEB_CMD_WRITE) begin
              // A different page must not join the open load; it waits until the load window closes.
              if (page_open_q && !same_page) begin
                cmd_ready <= 1'b0;
              end else begin
                mem_dq_out <= cmd_wdata;
                mem_dq_oe <= 1'b1;
                mem_cs_n <= 1'b0;
                page_q <= cmd_addr[14:6];
                // Erase code bytes from the user go out as plain writes.
                last_q <= cmd_last;
                last_wdata_q <= cmd_wdata;
                last_addr_q <= cmd_addr;
                state_q <= peb_pkg::PEB_ST_WR_SETUP;
              end
            end else if (cmd_op == peb_pkg::PEB_CMD_ERASE) begin
              mem_cs_n <= 1'b0;
              state_q <= peb_pkg::PEB_ST_ER_SETUP;
            end else begin
              mem_cs_n <= 1'b0;
              mem_oe_n <= 1'b0;
              if (cmd_op == peb_pkg::PEB_CMD_POLL) begin
                mem_addr <= last_addr_q;
                state_q <= peb_pkg::PEB_ST_POLL_RD;
              end else begin
                state_q <= peb_pkg::PEB_ST_RD_ACC;
              end
            end
          end
        end
        peb_pkg::PEB_ST_RD_ACC: begin
          if (tmr_done) begin
            rsp_rdata <= mem_dq_in;
            rsp_valid <= 1'b1;
            mem_oe_n <= 1'b1;
            mem_cs_n <= 1'b1;
            state_q <= peb_pkg::PEB_ST_IDLE;
          end
        end
        peb_pkg::PEB_ST_WR_SETUP: begin
          if (tmr_done) begin
            mem_we_n <= 1'b0;
            state_q <= peb_pkg::PEB_ST_WR_LOW;
          end
        end
        peb_pkg::PEB_ST_WR_LOW: begin
          // Gate stays high for the whole low phase; data is taken on this rise.
          if (tmr_done) begin
            mem_we_n <= 1'b1;
            state_q <= peb_pkg::PEB_ST_WR_HIGH;
          end
        end
        peb_pkg::PEB_ST_WR_HIGH: begin
          if (tmr_done) begin
            mem_cs_n <= 1'b1;
            mem_dq_oe <= 1'b0;
            page_open_q <= 1'b1;
            state_q <= last_q ? peb_pkg::PEB_ST_PROG_WAIT : peb_pkg::PEB_ST_PAGE_WAIT;
          end
        end
        peb_pkg::PEB_ST_PAGE_WAIT: begin
          if (tmr_done) begin
            state_q <= peb_pkg::PEB_ST_PROG_WAIT;
          end else if (cmd_valid && cmd_op == peb_pkg::PEB_CMD_WRITE && same_page) begin
            cmd_ready <= 1'b1;
            last_q <= cmd_last;
            mem_addr <= cmd_addr;
            mem_dq_out <= cmd_wdata;
            mem_dq_oe <= 1'b1;
            mem_cs_n <= 1'b0;
            last_wdata_q <= cmd_wdata;
            last_addr_q <= cmd_addr;
            state_q <= peb_pkg::PEB_ST_WR_SETUP;
          end
        end
        peb_pkg::PEB_ST_PROG_WAIT: begin
          page_open_q <= 1'b0;
          state_q <= peb_pkg::PEB_ST_IDLE;
        end
        peb_pkg::PEB_ST_POLL_RD: begin
          if (tmr_done) begin
            mem_oe_n <= 1'b1;
            prev_toggle_q <= mem_dq_in[6];
            rsp_rdata <= mem_dq_in;
            // Done once polling bit matches bit 7 of the last written byte and the alternating bit held still.
            rsp_valid <= (mem_dq_in[7] == last_wdata_q[7])
              && (mem_dq_in[6] == prev_toggle_q);
            rsp_timeout <= (wc_q >= 24'(WC_CYCLES));
            state_q <= peb_pkg::PEB_ST_POLL_GAP;
          end
        end
        peb_pkg::PEB_ST_POLL_GAP: begin
          if ((rsp_valid || rsp_timeout) && !tmr_load) begin
            mem_cs_n <= 1'b1;
            rsp_timeout <= 1'b0;
            state_q <= peb_pkg::PEB_ST_IDLE;
          end else if (tmr_done) begin
            mem_oe_n <= 1'b0;
            state_q <= peb_pkg::PEB_ST_POLL_RD;
          end
        end
        peb_pkg::PEB_ST_ER_SETUP: begin
          mem_oe_elevated <= 1'b1;
          if (tmr_done) begin
            mem_we_n <= 1'b0;
            state_q <= peb_pkg::PEB_ST_ER_PULSE;
          end
        end
        peb_pkg::PEB_ST_ER_PULSE: begin
          if (tmr_done) begin
            mem_we_n <= 1'b1;
            state_q <= peb_pkg::PEB_ST_ER_HOLD;
          end
        end
        peb_pkg::PEB_ST_ER_HOLD: begin
          if (tmr_done) begin
            mem_oe_elevated <= 1'b0;
            mem_cs_n <= 1'b1;
            rsp_valid <= 1'b1;
            state_q <= peb_pkg::PEB_ST_IDLE;
          end
        end
        default: begin
          state_q <= peb_pkg::PEB_ST_IDLE;
        end
      endcase
    end
  end

  // Time spent since the last write byte, for the programming time-out.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wc_q <= '0;
    end else if (state_q == peb_pkg::PEB_ST_WR_LOW) begin
      wc_q <= '0;
    end else if (wc_q != 24'hffffff) begin
      wc_q <= wc_q + 24'h000001;
    end
  end

  // Counts how long the strobe has been low, for the pulse width check.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      we_low_q <= '0;
    end else if (mem_we_n) begin
      we_low_q <= '0;
    end else if (we_low_q != 8'hff) begin
      we_low_q <= we_low_q + 8'h01;
    end
  end

  a_write_gate_high: assert property (@(posedge clk) disable iff (sys_rst)
    (!mem_we_n && !mem_cs_n) |-> mem_oe_n)
    else $error("gate low during write strobe");
  a_write_drives_bus: assert property (@(posedge clk) disable iff (sys_rst)
    !mem_we_n && !mem_oe_elevated |-> mem_dq_oe && !mem_cs_n)
    else $error("write strobe without data drive");
  a_read_no_drive: assert property (@(posedge clk) disable iff (sys_rst)
    !mem_oe_n |-> !mem_dq_oe && mem_we_n)
    else $error("read while host drives data");
  a_page_stable: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(mem_we_n) && !mem_oe_elevated |-> mem_addr[14:6] == page_q)
    else $error("page lines changed in load");
  a_strobe_width: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(mem_we_n) && !mem_oe_elevated |-> we_low_q >= 8'(peb_pkg::CYC_WP))
    else $error("write strobe too short");
  a_erase_pins: assert property (@(posedge clk) disable iff (sys_rst)
    mem_oe_elevated && !mem_we_n |-> !mem_cs_n && !mem_dq_oe)
    else $error("erase pin pattern wrong");
  a_id_top_range: assert property (@(posedge clk) disable iff (sys_rst)
    mem_id_elevated && !mem_cs_n |-> mem_addr >= peb_pkg::ID_BASE)
    else $error("id area outside top range");
  a_standby_float: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == peb_pkg::PEB_ST_IDLE && $past(state_q) == peb_pkg::PEB_ST_IDLE
    |-> mem_cs_n && !mem_dq_oe)
    else $error("bus not idle in standby");
  a_page_gap: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(mem_we_n) |-> ##[1:1000] (mem_cs_n || !mem_we_n))
    else $error("page byte cycle did not end");

  c_read: cover property (@(posedge clk) rsp_valid && state_q == peb_pkg::PEB_ST_IDLE);
  c_page: cover property (@(posedge clk)
    $fell(mem_we_n) && state_q == peb_pkg::PEB_ST_WR_SETUP && page_open_q);
  c_poll: cover property (@(posedge clk) state_q == peb_pkg::PEB_ST_POLL_GAP && rsp_valid);
  c_erase: cover property (@(posedge clk) mem_oe_elevated && !mem_we_n);

endmodule
`default_nettype wire

// [rtl/peb_pkg.sv]
// Package of timing counts, sequencer states and command codes for the paged memory host controller.
package peb_pkg;

  localparam int unsigned CLK_MHZ = 125;
  // Address and data widths, page size and ID area range of the byte-wide memory.
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PAGE_BYTES = 64;
  localparam logic [14:0] ID_BASE = 15'h7fc0;
  localparam logic [14:0] ID_LAST = 15'h7fff;
  // Pin timing in nanoseconds, microseconds or milliseconds as named; counts round up for least times.
  localparam int unsigned T_WP_NS = 100;
  localparam int unsigned T_WPH_NS = 50;
  localparam int unsigned T_DS_NS = 50;
  localparam int unsigned T_AH_NS = 50;
  localparam int unsigned T_ACC_NS = 350;
  localparam int unsigned T_DF_NS = 70;
  localparam int unsigned T_OEHP_NS = 150;
  localparam int unsigned T_ERASE_SETUP_US = 5;
  localparam int unsigned T_ERASE_PULSE_MS = 10;
  localparam int unsigned T_BLC_US = 150;
  localparam int unsigned T_WC_SLOW_MS = 10;
  localparam int unsigned CYC_WP = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CYC_WPH = (T_WPH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CYC_ACC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CYC_DF = (T_DF_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CYC_OEHP = (T_OEHP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CYC_ERASE_SETUP = T_ERASE_SETUP_US * CLK_MHZ;
  // Longest gap between page bytes rounds down.
  localparam int unsigned CYC_BLC = T_BLC_US * CLK_MHZ;
  localparam int unsigned CYC_ERASE_PULSE = T_ERASE_PULSE_MS * 1000 * CLK_MHZ;
  localparam int unsigned CYC_WC_SLOW = T_WC_SLOW_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W = 24;

  typedef enum logic [1:0] {
    PEB_CMD_READ = 2'b00,
    PEB_CMD_WRITE = 2'b01,
    PEB_CMD_ERASE = 2'b10,
    PEB_CMD_POLL = 2'b11
  } peb_cmd_e;

  typedef enum logic [3:0] {
    PEB_ST_IDLE = 4'b0000,
    PEB_ST_RD_ACC = 4'b0001,
    PEB_ST_RD_DONE = 4'b0010,
    PEB_ST_WR_SETUP = 4'b0011,
    PEB_ST_WR_LOW = 4'b0100,
    PEB_ST_WR_HIGH = 4'b0101,
    PEB_ST_PAGE_WAIT = 4'b0110,
    PEB_ST_PROG_WAIT = 4'b0111,
    PEB_ST_POLL_RD = 4'b1000,
    PEB_ST_POLL_GAP = 4'b1001,
    PEB_ST_ER_SETUP = 4'b1010,
    PEB_ST_ER_PULSE = 4'b1011,
    PEB_ST_ER_HOLD = 4'b1100
  } peb_state_e;

endpackage

// [rtl/peb_timer.sv]
// Down-counting delay timer used for every pin timing of the host controller.
`timescale 1ns/1ps
`default_nettype none
module peb_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Load and status
  input wire logic load,
  input wire logic [peb_pkg::CNT_W-1:0] count,
  output logic done
);

  logic [peb_pkg::CNT_W-1:0] cnt_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= count;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // Done is high in the cycle the count reaches one, so a load of n waits n cycles.
  // Done does not look at load, so a state may reload on done without a loop.
  assign done = (cnt_q == {{(peb_pkg::CNT_W-1){1'b0}}, 1'b1});

endmodule
`default_nettype wire

// [test/peb_mem_model.sv]
// Behavioural pin-level model of the paged byte-wide memory.
`timescale 1ns/1ps
`default_nettype none
module peb_mem_model #(
  parameter int unsigned BLC = 250,
  parameter int unsigned PROG = 400
) (
  // Model timing clock
  input wire logic clk,
  // Memory pins
  input wire logic [14:0] mem_addr,
  input wire logic mem_cs_n,
  input wire logic mem_oe_n,
  input wire logic mem_we_n,
  input wire logic mem_oe_elevated,
  input wire logic mem_id_elevated,
  input wire logic [7:0] mem_dq_out,
  input wire logic mem_dq_oe,
  output logic [7:0] mem_dq_in,
  // Host pin faults seen
  output logic [15:0] host_faults
);
  logic [7:0] arr [0:32767];
  logic [7:0] id_arr [0:63];
  logic [7:0] pbuf [0:63];
  logic [63:0] pmask;
  logic [14:0] la, last_a;
  logic [8:0] pg;
  logic lid, pid, strobe_q, rd_q, er_q, tgl, loading;
  logic [7:0] last_d, bus;
  int win, prog;
  wire strobe = !mem_cs_n && !mem_we_n;
  wire rd = !mem_cs_n && !mem_oe_n && mem_we_n && !mem_oe_elevated;
  wire ok_wr = mem_oe_n && !mem_oe_elevated && prog == 0;
  wire er = strobe && mem_oe_elevated;
  // The device counts as busy from the first loaded byte until programming ends.
  wire busy = loading || prog != 0;
  wire idsel = mem_id_elevated && mem_addr >= 15'h7fc0;
  initial begin
    for (int i = 0; i < 32768; i++) arr[i] = i[7:0] ^ 8'h5a;
    for (int i = 0; i < 64; i++) id_arr[i] = 8'h00;
    {strobe_q, rd_q, er_q, tgl, loading, lid, pid, pmask} = '0;
    {la, last_a, pg, last_d, bus, host_faults} = '0;
    win = 0;
    prog = 0;
  end
  always @(posedge clk) begin
    strobe_q <= strobe;
    rd_q <= rd;
    er_q <= er;
    bus <= mem_dq_in;
    // Contention, early gate and a page change inside a load are host faults, counted for the bench.
    if ((strobe && !mem_oe_n && !mem_oe_elevated) || (rd && mem_dq_oe)) begin
      host_faults <= host_faults + 16'h0001;
    end else if (strobe && !strobe_q && ok_wr && loading && mem_addr[14:6] != pg) begin
      host_faults <= host_faults + 16'h0001;
    end
    if (strobe && !strobe_q && ok_wr) begin
      la <= mem_addr;
      lid <= idsel;
    end
    if (!strobe && strobe_q && ok_wr) begin
      pbuf[la[5:0]] <= mem_dq_oe ? mem_dq_out : ~bus;
      pmask[la[5:0]] <= 1'b1;
      last_a <= la;
      last_d <= mem_dq_oe ? mem_dq_out : ~bus;
      loading <= 1'b1;
      win <= BLC;
      if (!loading) begin
        pg <= la[14:6];
        pid <= lid;
      end
    end else if (loading && win > 1) begin
      win <= win - 1;
    end else if (loading) begin
      loading <= 1'b0;
      prog <= PROG;
    end
    if (prog > 0) prog <= prog - 1;
    if (prog == 1) begin
      for (int i = 0; i < 64; i++) begin
        if (pmask[i] && pid) id_arr[i] <= pbuf[i];
        if (pmask[i] && !pid) arr[{pg, i[5:0]}] <= pbuf[i];
      end
      pmask <= '0;
    end
    if (rd && !rd_q && busy) tgl <= ~tgl;
    if (er_q && !er) begin
      for (int i = 0; i < 32768; i++) arr[i] <= 8'hff;
    end
  end
  always_comb begin
    if (!rd) mem_dq_in = ~bus;
    else if (busy) mem_dq_in = {(mem_addr == last_a) ? ~last_d[7] : 1'b0, tgl, last_d[5:0]};
    else if (idsel) mem_dq_in = id_arr[mem_addr[5:0]];
    else mem_dq_in = arr[mem_addr];
  end
endmodule
`default_nettype wire

// [test/test_peb_host.sv]
// Testbench of the paged memory host controller against the memory model.
`timescale 1ns/1ps
`default_nettype none
module test_peb_host;
  logic clk, sys_rst, cmd_valid, cmd_id_area, cmd_last, cmd_ready, rsp_valid, rsp_timeout;
  logic [1:0] cmd_op;
  logic [14:0] cmd_addr, mem_addr;
  logic [7:0] cmd_wdata, rsp_rdata, mem_dq_in, mem_dq_out;
  logic mem_cs_n, mem_oe_n, mem_we_n, mem_oe_elevated, mem_id_elevated, mem_dq_oe;
  logic [15:0] host_faults;
  int err_total, compares, cycles;
  peb_host #(.WC_CYCLES(2000), .BLC_CYCLES(200), .ERASE_CYCLES(50), .ERASE_SETUP_CYCLES(10)) dut (
    .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_id_area(cmd_id_area), .cmd_last(cmd_last), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_timeout(rsp_timeout), .mem_addr(mem_addr),
    .mem_cs_n(mem_cs_n), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n),
    .mem_oe_elevated(mem_oe_elevated), .mem_id_elevated(mem_id_elevated),
    .mem_dq_in(mem_dq_in), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe));
  peb_mem_model mem (
    .clk(clk), .mem_addr(mem_addr), .mem_cs_n(mem_cs_n), .mem_oe_n(mem_oe_n),
    .mem_we_n(mem_we_n), .mem_oe_elevated(mem_oe_elevated),
    .mem_id_elevated(mem_id_elevated), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe),
    .mem_dq_in(mem_dq_in), .host_faults(host_faults));
  task automatic stop_test();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: byte %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: flag %b expected %b", $time, g, e);
    end
  endtask
  // Called at a falling edge; holds the request until cmd_ready is seen.
  task automatic req(input logic [1:0] op, input logic id, input logic last,
                     input logic [14:0] a, input logic [7:0] d);
    int n;
    cmd_op = op;
    cmd_id_area = id;
    cmd_last = last;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 30000);
    cmd_valid = 1'b0;
    chk1(cmd_ready, 1'b1);
    // Let one edge pass so a following request never re-raises valid in this step.
    @(negedge clk);
  endtask
  task automatic wait_rsp(output logic [7:0] r, output logic to);
    int n;
    n = 0;
    while (rsp_valid !== 1'b1 && rsp_timeout !== 1'b1 && n < 30000) begin
      @(negedge clk);
      n++;
    end
    r = rsp_rdata;
    to = rsp_timeout;
    @(negedge clk);
  endtask
  task automatic rd_chk(input logic [14:0] a, input logic id, input logic [7:0] e);
    logic [7:0] r;
    logic to;
    req(peb_pkg::PEB_CMD_READ, id, 1'b0, a, 8'h00);
    wait_rsp(r, to);
    chk8(r, e);
  endtask
  task automatic poll_ok(input logic [14:0] a, input logic id, input logic [7:0] d);
    logic [7:0] r;
    logic to;
    req(peb_pkg::PEB_CMD_POLL, id, 1'b0, a, 8'h00);
    wait_rsp(r, to);
    chk1(to, 1'b0);
    chk8(r, d);
  endtask
  task automatic t_reset();
    chk1(mem_cs_n & mem_we_n & mem_oe_n, 1'b1);
    chk1(mem_dq_oe | mem_oe_elevated | mem_id_elevated, 1'b0);
  endtask
  task automatic t_byte();
    req(peb_pkg::PEB_CMD_WRITE, 1'b0, 1'b1, 15'h0123, 8'ha7);
    poll_ok(15'h0123, 1'b0, 8'ha7);
    rd_chk(15'h0123, 1'b0, 8'ha7);
    rd_chk(15'h0124, 1'b0, 8'h7e);
  endtask
  // Bytes loaded out of order at both ends of one page.
  task automatic t_page();
    req(peb_pkg::PEB_CMD_WRITE, 1'b0, 1'b0, 15'h027f, 8'h11);
    req(peb_pkg::PEB_CMD_WRITE, 1'b0, 1'b0, 15'h0240, 8'h22);
    req(peb_pkg::PEB_CMD_WRITE, 1'b0, 1'b1, 15'h0255, 8'h80);
    poll_ok(15'h0255, 1'b0, 8'h80);
    rd_chk(15'h027f, 1'b0, 8'h11);
    rd_chk(15'h0240, 1'b0, 8'h22);
    rd_chk(15'h0255, 1'b0, 8'h80);
  endtask
  task automatic t_id();
    req(peb_pkg::PEB_CMD_WRITE, 1'b1, 1'b1, 15'h7fc5, 8'h3c);
    poll_ok(15'h7fc5, 1'b1, 8'h3c);
    rd_chk(15'h7fc5, 1'b1, 8'h3c);
    rd_chk(15'h7fc5, 1'b0, 8'h9f);
  endtask
  task automatic t_erase();
    logic [7:0] r;
    logic to;
    req(peb_pkg::PEB_CMD_ERASE, 1'b0, 1'b0, 15'h0000, 8'h00);
    wait_rsp(r, to);
    chk1(to, 1'b0);
    rd_chk(15'h0123, 1'b0, 8'hff);
    rd_chk(15'h7fc5, 1'b0, 8'hff);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Whole run needs a few thousand cycles; the ceiling leaves wide margin.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    {sys_rst, cmd_valid, cmd_id_area, cmd_last} = 4'h8;
    cmd_op = 2'h0;
    cmd_addr = 15'h0000;
    cmd_wdata = 8'h00;
    err_total = 0;
    compares = 0;
    cycles = 0;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_byte();
    t_page();
    t_id();
    t_erase();
    chk1(host_faults == 16'h0000, 1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
